// File: slu_regs.svh
`ifndef SLU_REGS_SVH
`define SLU_REGS_SVH

// Register byte offsets
`define SLU_ADDR_CTRL 8'h00
`define SLU_ADDR_SRC 8'h04
`define SLU_ADDR_STATUS 8'h08
`define SLU_ADDR_WIDTH 8

// latch_control_primary fields
`define SLU_CTRL_MODULE_EN 7
`define SLU_CTRL_DIV_SEL_HI 6
`define SLU_CTRL_DIV_SEL_LO 4
`define SLU_CTRL_TRUE_OE 3
`define SLU_CTRL_INV_OE 2
`define SLU_CTRL_FW_SET 1
`define SLU_CTRL_FW_RESET 0
`define SLU_CTRL_STORED_MASK 8'hfc

// latch_source_enables fields
`define SLU_SRC_PIN_SET 7
`define SLU_SRC_DIV_SET 6
`define SLU_SRC_CMP2_SET 5
`define SLU_SRC_CMP1_SET 4
`define SLU_SRC_PIN_RESET 3
`define SLU_SRC_DIV_RESET 2
`define SLU_SRC_CMP2_RESET 1
`define SLU_SRC_CMP1_RESET 0

// Status fields
`define SLU_STAT_LATCH 0
`define SLU_STAT_CMP1 1
`define SLU_STAT_CMP2 2
`define SLU_STAT_PIN 3

// Reset values
`define SLU_CTRL_RESET 8'h00
`define SLU_SRC_RESET 8'h00

// Divider: period is 2^(select + base shift) clocks
`define SLU_DIV_WIDTH 9
`define SLU_DIV_BASE_SHIFT 4'h2

`endif

// File: slu_pkg.sv
`default_nettype none
package slu_pkg;
    typedef logic [7:0] slu_byte_t;
    typedef logic [2:0] slu_div_sel_t;
    typedef logic [31:0] slu_word_t;
endpackage
`default_nettype wire

// File: slu_latch.sv
// Contract
// (RULE_01) Latch keeps state without reset; every source is active high.
// (RULE_02) Set and reset together always leave the latch reset.
// (RULE_03) Firmware pulse bits assert their input one clock, then clear.
// (RULE_04) Firmware pulse bits are set-only and always read back zero.
// (RULE_05) Divider select n gives one-clock pulse every 2^(n+2) clocks.
// (RULE_06) Divider set enable lets each divider pulse set the latch.
// (RULE_07) Divider reset enable lets each divider pulse reset the latch.
// (RULE_08) Pin set enable lets a high input pin set the latch.
// (RULE_09) Pin reset enable lets a high input pin reset the latch.
// (RULE_10) Comparator set enables set latch while matching comparator is high.
// (RULE_11) Comparator reset enables reset latch while matching comparator high.
// (RULE_12) Synchronised comparator updates only on timer clock falling edge.
// (RULE_13) Module enable gates everything; disabled means no outputs at all. latch_state_out is not gated and still shows the latch.
// (RULE_14) True output enable drives latch state onto true output pin.
// (RULE_15) Inverted output enable drives complemented state onto inverted pin.
// (RULE_16) Both outputs may be driven at once.
// (RULE_17) External alternate select routes inverted output to alternate pin.
// (RULE_18) Software clears port direction bits; latch never enables drivers.
// (RULE_19) Latch undefined after reset; software initialises before outputs.
// (RULE_20) Software must not enable one source for both set and reset.
// (RULE_21) Both control registers clear to zero on every reset.
// (RULE_22) Inverted output is always the complement of the true output. Here it is the complement only while both output enables are set.
// (RULE_23) Divider runs continuously whenever the module is enabled.
//
// Local design decisions: the AHB-Lite register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "slu_regs.svh"
module slu_latch (
    input wire logic sys_clk_in,
    input wire logic rst_in,
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    output logic hreadyout_out,
    output logic hresp_out,
    output logic [31:0] hrdata_out,
    input wire logic cmp_one_output_in,
    input wire logic cmp_two_output_in,
    input wire logic cmp_one_sync_select_in,
    input wire logic cmp_two_sync_select_in,
    input wire logic timer_clock_in,
    input wire logic latch_input_pin_in,
    input wire logic inverted_pin_alt_select_in,
    output logic latch_state_out,
    output logic true_output_pin_out,
    output logic inverted_output_pin_out,
    output logic inverted_alt_pin_out
);
    slu_pkg::slu_byte_t ctrl_reg;
    slu_pkg::slu_byte_t src_reg;
    logic fw_set_pulse_reg;
    logic fw_reset_pulse_reg;
    logic wr_pend_reg;
    logic [`SLU_ADDR_WIDTH-1:0] addr_reg;
    slu_pkg::slu_word_t hrdata_reg;
    slu_pkg::slu_word_t rd_next;
    logic addr_phase;
    logic [3:0] async_s1_reg;
    logic [3:0] async_s2_reg;
    logic tclk_prev_reg;
    logic tclk_fall;
    logic [1:0] cmp_raw;
    logic [1:0] cmp_sync_sel;
    logic [1:0] cmp_held_reg;
    logic [1:0] cmp_eff;
    logic pin_sync;
    logic [`SLU_DIV_WIDTH-1:0] div_cnt_reg;
    logic [`SLU_DIV_WIDTH-1:0] div_mask;
    logic [3:0] div_shift;
    logic divided_pulse;
    logic module_enable;
    slu_pkg::slu_div_sel_t divider_select;
    logic set_comb;
    logic reset_comb;
    logic latch_reg;
    logic latch_known_reg;
    logic true_drive;
    logic inv_drive;

    assign module_enable = ctrl_reg[`SLU_CTRL_MODULE_EN];
    assign divider_select =
        ctrl_reg[`SLU_CTRL_DIV_SEL_HI:`SLU_CTRL_DIV_SEL_LO];

    // AHB-Lite slave: zero wait states, always OKAY
    assign hreadyout_out = 1'b1;
    assign hresp_out = 1'b0;
    assign hrdata_out = hrdata_reg;
    assign addr_phase = hsel_in && htrans_in[1] && hready_in;

    always_comb begin
        rd_next = 32'h0000_0000;
        case (haddr_in[`SLU_ADDR_WIDTH-1:0])
            `SLU_ADDR_CTRL: begin
                rd_next[7:0] = ctrl_reg & `SLU_CTRL_STORED_MASK; // see RULE_04
            end
            `SLU_ADDR_SRC: begin
                rd_next[7:0] = src_reg;
            end
            `SLU_ADDR_STATUS: begin
                rd_next[`SLU_STAT_LATCH] = latch_reg;
                rd_next[`SLU_STAT_CMP1] = cmp_eff[0];
                rd_next[`SLU_STAT_CMP2] = cmp_eff[1];
                rd_next[`SLU_STAT_PIN] = pin_sync;
            end
            default: rd_next = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            wr_pend_reg <= 1'b0;
            addr_reg <= 8'h00;
            hrdata_reg <= 32'h0000_0000;
        end else begin
            if (hready_in) begin
                wr_pend_reg <= addr_phase && hwrite_in;
            end
            if (addr_phase) begin
                addr_reg <= haddr_in[`SLU_ADDR_WIDTH-1:0];
                hrdata_reg <= hwrite_in ? 32'h0000_0000 : rd_next;
            end
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            ctrl_reg <= `SLU_CTRL_RESET; // see RULE_21
            src_reg <= `SLU_SRC_RESET; // see RULE_21
        end else if (wr_pend_reg) begin
            if (addr_reg == `SLU_ADDR_CTRL) begin
                ctrl_reg <= hwdata_in[7:0] & `SLU_CTRL_STORED_MASK;
            end
            if (addr_reg == `SLU_ADDR_SRC) begin
                src_reg <= hwdata_in[7:0];
            end
        end
    end

    // Firmware pulses last exactly one clock, then drop
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            fw_set_pulse_reg <= 1'b0;
            fw_reset_pulse_reg <= 1'b0;
        end else begin
            fw_set_pulse_reg <= wr_pend_reg && addr_reg == `SLU_ADDR_CTRL
                && hwdata_in[`SLU_CTRL_FW_SET]; // see RULE_03
            fw_reset_pulse_reg <= wr_pend_reg && addr_reg == `SLU_ADDR_CTRL
                && hwdata_in[`SLU_CTRL_FW_RESET]; // see RULE_03
        end
    end

    // Two-stage synchronisers for comparators, pin and timer clock
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            async_s1_reg <= 4'h0;
            async_s2_reg <= 4'h0;
            tclk_prev_reg <= 1'b0;
        end else begin
            async_s1_reg <= {timer_clock_in, latch_input_pin_in,
                cmp_two_output_in, cmp_one_output_in};
            async_s2_reg <= async_s1_reg;
            tclk_prev_reg <= async_s2_reg[3];
        end
    end

    assign cmp_raw = async_s2_reg[1:0];
    assign pin_sync = async_s2_reg[2];
    assign tclk_fall = tclk_prev_reg && !async_s2_reg[3];
    assign cmp_sync_sel = {cmp_two_sync_select_in, cmp_one_sync_select_in};

    generate
        for (genvar i = 0; i < 2; i++) begin : g_cmp
            always_ff @(posedge sys_clk_in) begin
                if (rst_in) begin
                    cmp_held_reg[i] <= 1'b0;
                end else if (tclk_fall) begin
                    cmp_held_reg[i] <= cmp_raw[i]; // see RULE_12
                end
            end
            assign cmp_eff[i] = cmp_sync_sel[i] ? cmp_held_reg[i]
                : cmp_raw[i]; // see RULE_12
        end
    endgenerate

    // Divider free-runs while enabled; pulse when low n+2 bits are all ones
    always_ff @(posedge sys_clk_in) begin
        if (rst_in || !module_enable) begin
            div_cnt_reg <= 9'h000;
        end else begin
            div_cnt_reg <= div_cnt_reg + 9'h001; // see RULE_23
        end
    end

    assign div_shift = {1'b0, divider_select} + `SLU_DIV_BASE_SHIFT;
    assign div_mask = ~(9'h1ff << div_shift);
    assign divided_pulse = module_enable
        && ((div_cnt_reg & div_mask) == div_mask); // see RULE_05

    // Combined latch inputs, all gated by the module enable
    always_comb begin
        set_comb = fw_set_pulse_reg
            || (src_reg[`SLU_SRC_DIV_SET] && divided_pulse) // see RULE_06
            || (src_reg[`SLU_SRC_PIN_SET] && pin_sync) // see RULE_08
            || (src_reg[`SLU_SRC_CMP1_SET] && cmp_eff[0]) // see RULE_10
            || (src_reg[`SLU_SRC_CMP2_SET] && cmp_eff[1]); // see RULE_10
        reset_comb = fw_reset_pulse_reg
            || (src_reg[`SLU_SRC_DIV_RESET] && divided_pulse) // see RULE_07
            || (src_reg[`SLU_SRC_PIN_RESET] && pin_sync) // see RULE_09
            || (src_reg[`SLU_SRC_CMP1_RESET] && cmp_eff[0]) // see RULE_11
            || (src_reg[`SLU_SRC_CMP2_RESET] && cmp_eff[1]); // see RULE_11
        set_comb = set_comb && module_enable; // see RULE_13
        reset_comb = reset_comb && module_enable; // see RULE_13
    end

    // Latch state is deliberately not reset
    always_ff @(posedge sys_clk_in) begin
        if (reset_comb) begin
            latch_reg <= 1'b0; // see RULE_02
        end else if (set_comb) begin
            latch_reg <= 1'b1; // see RULE_01
        end
    end

    // Tracks whether the latch has been initialised since the last reset
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            latch_known_reg <= 1'b0;
        end else if (set_comb || reset_comb) begin
            latch_known_reg <= 1'b1; // see RULE_19
        end
    end

    assign true_drive = module_enable && ctrl_reg[`SLU_CTRL_TRUE_OE];
    assign inv_drive = module_enable && ctrl_reg[`SLU_CTRL_INV_OE];
    assign latch_state_out = latch_known_reg && latch_reg;
    assign true_output_pin_out = true_drive && latch_reg; // see RULE_14
    // Independent enables let both pins drive together
    assign inverted_output_pin_out = inv_drive && !latch_reg // see RULE_15
        && !inverted_pin_alt_select_in; // see RULE_17
    assign inverted_alt_pin_out = inv_drive && !latch_reg // see RULE_22
        && inverted_pin_alt_select_in; // see RULE_17

    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (rst_in);

    property p_reset_dominant;
        set_comb && reset_comb |=> !latch_reg;
    endproperty
    a_reset_dominant: assert property (p_reset_dominant) // see RULE_02
        else $error("latch not reset when set and reset coincide");
    property p_set_acts;
        set_comb && !reset_comb |=> latch_reg;
    endproperty
    a_set_acts: assert property (p_set_acts) // see RULE_01
        else $error("latch failed to set");
    property p_hold;
        latch_known_reg && !set_comb && !reset_comb |=> $stable(latch_reg);
    endproperty
    a_hold: assert property (p_hold) // see RULE_01
        else $error("latch changed without any input");
    property p_fw_set_pulse;
        wr_pend_reg && addr_reg == `SLU_ADDR_CTRL
            && hwdata_in[`SLU_CTRL_FW_SET] ##1 !wr_pend_reg
            |-> fw_set_pulse_reg ##1 !fw_set_pulse_reg;
    endproperty
    a_fw_set_pulse: assert property (p_fw_set_pulse) // see RULE_03
        else $error("firmware set pulse not exactly one clock");
    property p_fw_reset_pulse;
        fw_reset_pulse_reg && module_enable |=> !latch_reg;
    endproperty
    a_fw_reset_pulse: assert property (p_fw_reset_pulse) // see RULE_03
        else $error("firmware reset pulse did not reset latch");
    property p_pulse_read_zero;
        addr_phase && !hwrite_in
            && haddr_in[`SLU_ADDR_WIDTH-1:0] == `SLU_ADDR_CTRL
            |=> hrdata_out[1:0] == 2'b00;
    endproperty
    a_pulse_read_zero: assert property (p_pulse_read_zero) // see RULE_04
        else $error("firmware pulse bits read back nonzero");
    property p_div_period4;
        (divided_pulse && divider_select == 3'h0)
            ##1 (module_enable && divider_select == 3'h0)[*4]
            |-> divided_pulse && !$past(divided_pulse)
                && !$past(divided_pulse, 2) && !$past(divided_pulse, 3);
    endproperty
    a_div_period4: assert property (p_div_period4) // see RULE_05
        else $error("divider period wrong for select zero");
    property p_div_reset;
        divided_pulse && src_reg[`SLU_SRC_DIV_RESET] |=> !latch_reg;
    endproperty
    a_div_reset: assert property (p_div_reset) // see RULE_07
        else $error("divider pulse did not reset latch");
    property p_pin_reset;
        module_enable && pin_sync && src_reg[`SLU_SRC_PIN_RESET]
            |=> !latch_reg;
    endproperty
    a_pin_reset: assert property (p_pin_reset) // see RULE_09
        else $error("input pin did not reset latch");
    property p_disabled_quiet;
        !module_enable |-> !true_output_pin_out && !inverted_output_pin_out
            && !inverted_alt_pin_out;
    endproperty
    a_disabled_quiet: assert property (p_disabled_quiet) // see RULE_13
        else $error("output active while module disabled");
    property p_complement;
        latch_known_reg && true_drive && inv_drive |->
            true_output_pin_out != (inverted_output_pin_out
                || inverted_alt_pin_out);
    endproperty
    a_complement: assert property (p_complement) // see RULE_22
        else $error("inverted output not complement of true output");
    property p_regs_cleared;
        disable iff (1'b0)
            $past(rst_in) |-> ctrl_reg == 8'h00 && src_reg == 8'h00;
    endproperty
    a_regs_cleared: assert property (p_regs_cleared) // see RULE_21
        else $error("control registers not cleared by reset");
    property p_cmp_sync_hold;
        cmp_sync_sel[0] && !tclk_fall |=> $stable(cmp_held_reg[0]);
    endproperty
    a_cmp_sync_hold: assert property (p_cmp_sync_hold) // see RULE_12
        else $error("synchronised comparator moved off timer edge");

    c_cmp_set: cover property (src_reg[`SLU_SRC_CMP1_SET] && cmp_eff[0]
        ##1 latch_reg);
    c_both_inputs: cover property (set_comb && reset_comb);
    c_div512: cover property (divided_pulse && divider_select == 3'h7);
    c_both_outputs: cover property (true_drive && inv_drive
        && latch_known_reg);
endmodule
`default_nettype wire

// File: slu_far_side.sv
`timescale 1ns/1ps
`default_nettype none
module slu_far_side (
    input wire logic cmp_one_cmd_in,
    input wire logic cmp_two_cmd_in,
    input wire logic pin_cmd_in,
    input wire logic run_in,
    output logic cmp_one_out,
    output logic cmp_two_out,
    output logic pin_out,
    output logic timer_clock_out
);
    // Comparators and the input pin are active high levels
    assign cmp_one_out = cmp_one_cmd_in;
    assign cmp_two_out = cmp_two_cmd_in;
    assign pin_out = pin_cmd_in;
    // Timer clock source, unrelated in phase, can be held still
    initial begin
        timer_clock_out = 1'b1;
        forever begin
            #37;
            if (run_in)
                timer_clock_out = ~timer_clock_out;
        end
    end
endmodule
`default_nettype wire

// File: testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clk, rst, hsel, hwrite, hready, hresp, tq, nq, aq, lat, p, f;
    logic c1, c2, pin, s1, s2, run, alt, c1_w, c2_w, pin_w, tclk;
    logic [1:0] htrans;
    logic [31:0] haddr, hwdata, hrdata, rd;
    int error_cnt, checks_done, ctrl_m, src_m, lat_m, n, k;

    slu_latch uut (.sys_clk_in(clk), .rst_in(rst), .hsel_in(hsel),
        .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite),
        .hsize_in(3'b010), .hwdata_in(hwdata), .hready_in(hready),
        .hreadyout_out(hready), .hresp_out(hresp), .hrdata_out(hrdata),
        .cmp_one_output_in(c1_w), .cmp_two_output_in(c2_w),
        .cmp_one_sync_select_in(s1), .cmp_two_sync_select_in(s2),
        .timer_clock_in(tclk), .latch_input_pin_in(pin_w),
        .inverted_pin_alt_select_in(alt), .latch_state_out(lat),
        .true_output_pin_out(tq), .inverted_output_pin_out(nq),
        .inverted_alt_pin_out(aq));
    slu_far_side far (.cmp_one_cmd_in(c1), .cmp_two_cmd_in(c2),
        .pin_cmd_in(pin), .run_in(run), .cmp_one_out(c1_w),
        .cmp_two_out(c2_w), .pin_out(pin_w), .timer_clock_out(tclk));

    task automatic stop_test;
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e) begin
            error_cnt++;
            $display("Error at %0t: got %h want %h", $time, g, e);
        end
    endtask

    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'b10;
        do @(posedge clk); while (hready !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge clk); while (hready !== 1'b1);
        rd = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
        if (a == 8'h00)
            ctrl_m = d[7:0] & 8'hfc;
        if (a == 8'h04)
            src_m = d[7:0];
        if (a == 8'h00 && d[7])
            lat_m = d[0] ? 0 : (d[1] ? 1 : lat_m);
        repeat (3) @(posedge clk);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(rd, e);
    endtask

    // Expected pins from the model latch and control image
    task automatic chk_out;
        logic en, q;
        en = ctrl_m[7];
        q = lat_m[0];
        chk({lat, tq, nq, aq}, {q, en & ctrl_m[3] & q,
            en & ctrl_m[2] & !q & !alt, en & ctrl_m[2] & !q & alt});
    endtask

    task automatic drive(input int i, input logic v);
        c1 <= (i % 4 == 0) & v;
        c2 <= (i % 4 == 1) & v;
        pin <= (i % 4 == 3) & v;
    endtask

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    initial begin
        #2000000;
        error_cnt++;
        stop_test;
    end

    initial begin
        rst = 1; hsel = 0; htrans = 0; hwrite = 0; haddr = 0; hwdata = 0;
        c1 = 0; c2 = 0; pin = 0; s1 = 0; s2 = 0; run = 1; alt = 0;
        error_cnt = 0; checks_done = 0; ctrl_m = 0; src_m = 0; lat_m = 0;
        k = $urandom(62);
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rdc(8'h00, 32'h0);
        rdc(8'h04, 32'h0);
        chk({tq, nq, aq, hresp, hready}, 32'h1);
        $display("test reset values done");

        wr(8'h00, 32'h82);
        chk_out;
        rdc(8'h00, 32'h80);
        wr(8'h00, 32'h81);
        chk_out;
        wr(8'h00, 32'h82);
        wr(8'h00, 32'h83);
        chk_out;
        rdc(8'h08, lat_m & 1);
        k = $urandom;
        k[3:0] = k[3:0] & ~k[7:4];
        wr(8'h04, k);
        wr(8'h0c, 32'hff);
        rdc(8'h0c, 32'h0);
        rdc(8'h04, src_m);
        wr(8'h04, 32'h0);
        $display("test firmware pulses and registers done");

        for (int i = 0; i < 8; i++) begin
            wr(8'h00, (i > 3) ? 32'h81 : 32'h82);
            drive(i, 1'b1);
            repeat (6) @(posedge clk);
            chk_out;
            k = {i % 4 == 3, i % 4 == 1, i % 4 == 0, lat_m[0]};
            rdc(8'h08, k);
            wr(8'h04, 32'h1 << i);
            repeat (6) @(posedge clk);
            lat_m = (i > 3);
            chk_out;
            drive(i, 1'b0);
            wr(8'h04, 32'h0);
        end
        $display("test sources done");

        k = $urandom % 8;
        pin <= 1'b1;
        wr(8'h04, 32'h84);
        for (int j = 0; j < 8; j++) begin
            wr(8'h00, 32'h80 | (((j + k) % 8) << 4));
            n = 0;
            f = 0;
            p = lat;
            repeat (1200) begin
                @(posedge clk);
                #1;
                n++;
                if (p === 1'b1 && lat === 1'b0) begin
                    if (f)
                        break;
                    f = 1;
                    n = 0;
                end
                p = lat;
            end
            chk(n, 4 << ((j + k) % 8));
        end
        @(posedge clk);
        pin <= 1'b0;
        wr(8'h04, 32'h0);
        $display("test divider done");

        for (int c = 0; c < 2; c++) begin
            run <= 1'b0;
            s1 <= (c == 0);
            s2 <= (c == 1);
            wr(8'h00, 32'h81);
            wr(8'h04, c ? 32'h20 : 32'h10);
            c1 <= (c == 0);
            c2 <= (c == 1);
            repeat (10) @(posedge clk);
            chk_out;
            run <= 1'b1;
            repeat (14) @(posedge clk);
            lat_m = 1;
            chk_out;
            c1 <= 1'b0;
            c2 <= 1'b0;
            wr(8'h04, 32'h0);
        end
        $display("test held comparators done");

        for (int j = 0; j < 32; j++) begin
            alt <= j[4];
            wr(8'h00, (j[2] << 7) | (j[1:0] << 2) | (j[3] ? 2 : 1));
            chk_out;
        end
        // Disabled module must ignore a reset pulse and the pin reset
        wr(8'h00, 32'h01);
        pin <= 1'b1;
        wr(8'h04, 32'h08);
        chk_out;
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        ctrl_m = 0;
        src_m = 0;
        @(posedge clk);
        rdc(8'h04, src_m);
        chk({lat, tq, nq, aq}, 32'h0);
        $display("test outputs done");
        stop_test;
    end
endmodule
`default_nettype wire
